// ---- fsf_consts.svh ----
// Constants of the fault status flag block: offsets, bit positions, reset values.
// Assumes a 32-bit plain register port with an 8-bit byte address.
//
// Behaviour
// - Instruction bus error flag sets only when a prefetch-faulted instruction is issued.
// - An instruction bus error never loads the bus fault address capture.
// - Each flag stays set until software writes one to it; zero leaves it.
// - Address-valid flag is high exactly while the memory fault address capture is valid.
// - Reserved bits read zero and ignore writes; software preserves them.
// - Stacking violation flag sets when exception-entry stacking hits access violations.
// - On stacking violation the stack pointer still adjusts; no memory address capture.
// - A precise data bus error loads its address into the bus fault capture.
`ifndef FSF_CONSTS_SVH
`define FSF_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define FSF_OFS_STATUS   8'h00
`define FSF_OFS_MASK     8'h04
`define FSF_OFS_MM_ADDR  8'h08
`define FSF_OFS_BUS_ADDR 8'h0C

// ----------------------------------------------------------------
// Field positions in status and mask
// ----------------------------------------------------------------
`define FSF_BIT_INSTR_ERR   8
`define FSF_BIT_ADDR_VALID  7
`define FSF_BIT_STACK_VIOL  4
`define FSF_FLAG_BITS       9'h190

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FSF_FLAG_RST     1'b0
`define FSF_MASK_RST     9'h000
`define FSF_ADDR_RST     32'h0000_0000
`define FSF_RDATA_RST    32'h0000_0000

`endif

// ---- fsf_pkg.sv ----
// Types of the fault status flag block.
// Assumes fsf_consts.svh supplies the numeric constants.
`default_nettype none

package fsf_pkg;
    // Exception-entry stacking phase, one-hot
    typedef enum logic [1:0] {
        FSF_STK_IDLE = 2'b01,
        FSF_STK_PUSH = 2'b10
    } fsf_stk_state_type;

    typedef logic [7:0]  fsf_addr_type;
    typedef logic [31:0] fsf_word_type;
endpackage

`default_nettype wire

// ---- fsf_capture.sv ----
// Fault address capture register: holds the last address loaded.
// Assumes load is a one-cycle pulse from the fault logic in the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "fsf_consts.svh"

module fsf_capture
    import fsf_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire fsf_word_type addr_in,
    output fsf_word_type      addr_out
);

    // ----------------------------------------------------------------
    // Capture storage
    // ----------------------------------------------------------------
    fsf_word_type addr_r;

    // Load on pulse, hold otherwise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_r <= `FSF_ADDR_RST;
        end else if (load) begin
            addr_r <= addr_in;
        end
    end

    assign addr_out = addr_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_capture_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !load |=> $stable(addr_r))
        else $error("capture changed without load");

endmodule
`default_nettype wire

// ---- fsf_top.sv ----
// Fault status flags with address captures, interrupt and register port.
// Assumes core fault events are one-cycle pulses synchronous to ref_clk.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "fsf_consts.svh"

module fsf_top
    import fsf_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Register port
    input  wire fsf_addr_type reg_addr,
    input  wire fsf_word_type reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output fsf_word_type      reg_rdata,
    // Instruction path
    input  wire logic         prefetch_err,
    input  wire logic         issue_fire,
    input  wire logic         issue_prefetch_err,
    // Data path
    input  wire logic         precise_data_err,
    input  wire fsf_word_type data_err_addr,
    input  wire logic         mm_data_viol,
    input  wire fsf_word_type mm_viol_addr,
    // Exception-entry stacking
    input  wire logic         stack_start,
    input  wire logic         stack_viol,
    input  wire logic         stack_done,
    output logic              sp_adjust,
    output logic              stack_ctx_suspect,
    // Status to core
    output logic              prefetch_err_pending,
    output logic              irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic              instr_bus_err_flag;
    logic              mm_addr_valid_flag;
    logic              stacking_violation_flag;
    logic [8:0]        mask_r;
    logic              pend_r;
    logic              suspect_r;
    fsf_word_type      rdata_r;
    fsf_word_type      rdata_nxt;
    fsf_word_type      bus_fault_addr_capture;
    fsf_word_type      mm_fault_addr_capture;
    fsf_stk_state_type stk_r;
    fsf_stk_state_type stk_nxt;
    logic [8:0]        status;
    logic              wr_status;
    logic              instr_err_set;
    logic              stack_viol_set;
    logic              bus_load;

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    // Flag only when the faulted instruction actually issues
    assign instr_err_set  = issue_fire && issue_prefetch_err;
    // Only a precise data error loads the bus capture
    assign bus_load       = precise_data_err;
    // Violations count only while pushing the entry context
    assign stack_viol_set = (stk_r == FSF_STK_PUSH) && stack_viol;
    assign wr_status      = reg_wr && (reg_addr == `FSF_OFS_STATUS);

    // ----------------------------------------------------------------
    // Sticky flags, set wins over write-one clear
    // ----------------------------------------------------------------
    // Instruction bus error flag
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            instr_bus_err_flag <= `FSF_FLAG_RST;
        end else if (instr_err_set) begin
            instr_bus_err_flag <= 1'b1;
        end else if (wr_status && reg_wdata[`FSF_BIT_INSTR_ERR]) begin
            instr_bus_err_flag <= 1'b0;
        end
    end

    // Address-valid flag follows loads of the memory fault capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mm_addr_valid_flag <= `FSF_FLAG_RST;
        end else if (mm_data_viol) begin
            mm_addr_valid_flag <= 1'b1;
        end else if (wr_status && reg_wdata[`FSF_BIT_ADDR_VALID]) begin
            mm_addr_valid_flag <= 1'b0;
        end
    end

    // Stacking violation flag
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stacking_violation_flag <= `FSF_FLAG_RST;
        end else if (stack_viol_set) begin
            stacking_violation_flag <= 1'b1;
        end else if (wr_status && reg_wdata[`FSF_BIT_STACK_VIOL]) begin
            stacking_violation_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Prefetch error waiting for issue
    // ----------------------------------------------------------------
    // Remembers a failed prefetch; does not touch the flag by itself
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else if (prefetch_err) begin
            pend_r <= 1'b1;
        end else if (issue_fire) begin
            pend_r <= 1'b0;
        end
    end

    assign prefetch_err_pending = pend_r;

    // ----------------------------------------------------------------
    // Stacking sequencer
    // ----------------------------------------------------------------
    // Next phase of exception-entry stacking
    always_comb begin
        stk_nxt = stk_r;
        case (stk_r)
            FSF_STK_IDLE: begin
                if (stack_start) begin
                    stk_nxt = FSF_STK_PUSH;
                end
            end
            FSF_STK_PUSH: begin
                if (stack_done) begin
                    stk_nxt = FSF_STK_IDLE;
                end
            end
            default: stk_nxt = FSF_STK_IDLE;
        endcase
    end

    // Phase register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stk_r <= FSF_STK_IDLE;
        end else begin
            stk_r <= stk_nxt;
        end
    end

    // Context marked suspect when this push saw a violation
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            suspect_r <= 1'b0;
        end else if (stack_start && (stk_r == FSF_STK_IDLE)) begin
            suspect_r <= 1'b0;
        end else if (stack_viol_set) begin
            suspect_r <= 1'b1;
        end
    end

    // Stack pointer adjusts at end of push, violation or not
    assign sp_adjust         = (stk_r == FSF_STK_PUSH) && stack_done;
    assign stack_ctx_suspect = suspect_r;

    // ----------------------------------------------------------------
    // Address captures
    // ----------------------------------------------------------------
    // Bus capture: precise data errors only, never instruction errors
    fsf_capture u_bus_cap (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .load     (bus_load),
        .addr_in  (data_err_addr),
        .addr_out (bus_fault_addr_capture)
    );

    // Memory capture: data access violations only, never stacking
    fsf_capture u_mm_cap (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .load     (mm_data_viol),
        .addr_in  (mm_viol_addr),
        .addr_out (mm_fault_addr_capture)
    );

    // ----------------------------------------------------------------
    // Mask and interrupt
    // ----------------------------------------------------------------
    // Mask holds only the implemented flag positions
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_r <= `FSF_MASK_RST;
        end else if (reg_wr && (reg_addr == `FSF_OFS_MASK)) begin
            mask_r <= reg_wdata[8:0] & `FSF_FLAG_BITS;
        end
    end

    // Status view; reserved positions tied low
    always_comb begin
        status                = 9'h000;
        status[`FSF_BIT_INSTR_ERR]  = instr_bus_err_flag;
        status[`FSF_BIT_ADDR_VALID] = mm_addr_valid_flag;
        status[`FSF_BIT_STACK_VIOL] = stacking_violation_flag;
    end

    assign irq = |(status & mask_r);

    // ----------------------------------------------------------------
    // Read path, data one cycle after the strobe
    // ----------------------------------------------------------------
    // Read mux; unmapped offsets return zero
    always_comb begin
        rdata_nxt = `FSF_RDATA_RST;
        if (reg_rd) begin
            if (reg_addr == `FSF_OFS_STATUS) begin
                rdata_nxt = {23'h000000, status};
            end else if (reg_addr == `FSF_OFS_MASK) begin
                rdata_nxt = {23'h000000, mask_r};
            end else if (reg_addr == `FSF_OFS_MM_ADDR) begin
                rdata_nxt = mm_fault_addr_capture;
            end else if (reg_addr == `FSF_OFS_BUS_ADDR) begin
                rdata_nxt = bus_fault_addr_capture;
            end
        end
    end

    // Read data register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= `FSF_RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking fsf_cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_instr_issue_only: assert property (
        !instr_bus_err_flag && !(issue_fire && issue_prefetch_err) |=> !instr_bus_err_flag)
        else $error("instruction bus flag set without faulted issue");

    a_instr_on_issue: assert property (
        issue_fire && issue_prefetch_err |=> instr_bus_err_flag [*2] or
        (instr_bus_err_flag ##1 1'b1))
        else $error("instruction bus flag missed");

    a_instr_no_capture: assert property (
        issue_fire && issue_prefetch_err && !precise_data_err
        |=> $stable(bus_fault_addr_capture))
        else $error("bus capture loaded by instruction error");

    a_w1c_zero_holds: assert property (
        stacking_violation_flag && wr_status && !reg_wdata[`FSF_BIT_STACK_VIOL]
        |=> stacking_violation_flag)
        else $error("flag cleared by writing zero");

    a_w1c_one_clears: assert property (
        instr_bus_err_flag && wr_status && reg_wdata[`FSF_BIT_INSTR_ERR] && !instr_err_set
        |=> !instr_bus_err_flag)
        else $error("flag not cleared by writing one");

    a_valid_load: assert property (
        mm_data_viol |=> mm_addr_valid_flag &&
        (mm_fault_addr_capture == $past(mm_viol_addr)))
        else $error("memory capture or valid flag wrong");

    a_reserved_zero: assert property (
        reg_rd && (reg_addr == `FSF_OFS_STATUS)
        |=> (reg_rdata[6:5] == 2'h0) && (reg_rdata[3:0] == 4'h0) &&
        (reg_rdata[31:9] == 23'h000000))
        else $error("reserved status bits not zero");

    a_stack_flag_set: assert property (
        (stk_r == FSF_STK_PUSH) && stack_viol |=> stacking_violation_flag ##1 1'b1)
        else $error("stacking violation flag missed");

    a_stack_no_capture: assert property (
        stack_viol && !mm_data_viol |=> $stable(mm_fault_addr_capture))
        else $error("memory capture loaded by stacking");

    a_stack_sp_adjust: assert property (
        (stk_r == FSF_STK_PUSH) && stack_done |-> sp_adjust ##1 (stk_r == FSF_STK_IDLE))
        else $error("stack pointer not adjusted");

    a_precise_load: assert property (
        precise_data_err |=> bus_fault_addr_capture == $past(data_err_addr))
        else $error("bus capture missed precise error");

    a_reset_clear: assert property (@(posedge ref_clk) disable iff (1'b0)
        rst |=> !instr_bus_err_flag && !mm_addr_valid_flag && !stacking_violation_flag)
        else $error("flags not cleared by reset");

    a_valid_clear: assert property (
        mm_addr_valid_flag && wr_status && reg_wdata[`FSF_BIT_ADDR_VALID] && !mm_data_viol
        |=> !mm_addr_valid_flag)
        else $error("address-valid flag not cleared by writing one");

    a_stack_event_only: assert property (
        !stacking_violation_flag && !((stk_r == FSF_STK_PUSH) && stack_viol)
        |=> !stacking_violation_flag)
        else $error("stacking flag set without violation in push");

    c_instr_event: cover property (issue_fire && issue_prefetch_err ##1 irq);
    c_stack_viol:  cover property (stack_start ##[1:8] stack_viol ##[1:8] sp_adjust);
    c_set_and_clr: cover property (wr_status && reg_wdata[`FSF_BIT_ADDR_VALID] && mm_data_viol);
    c_valid_clear: cover property (mm_addr_valid_flag && wr_status &&
        reg_wdata[`FSF_BIT_ADDR_VALID] ##1 !mm_addr_valid_flag);

endmodule
`default_nettype wire

// ---- fsf_top_test.sv ----
// Self-checking testbench of the fault status flag block, with a bench model.
// Assumes fsf_consts.svh and fsf_pkg are compiled first; one 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "fsf_consts.svh"

module fsf_top_test
    import fsf_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus, design outputs and model state
    // ------------------------------------------------------------
    logic         ref_clk;
    logic         rst;
    fsf_addr_type reg_addr;
    fsf_word_type reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    fsf_word_type reg_rdata;
    logic         prefetch_err;
    logic         issue_fire;
    logic         issue_prefetch_err;
    logic         precise_data_err;
    fsf_word_type data_err_addr;
    logic         mm_data_viol;
    fsf_word_type mm_viol_addr;
    logic         stack_start;
    logic         stack_viol;
    logic         stack_done;
    logic         sp_adjust;
    logic         stack_ctx_suspect;
    logic         prefetch_err_pending;
    logic         irq;
    logic [8:0]   m_stat;
    logic [8:0]   m_mask;
    logic [31:0]  m_mm;
    logic [31:0]  m_bus;
    logic [31:0]  m_rd;
    logic         m_push;
    logic         m_susp;
    logic         m_pend;
    logic [31:0]  seed;
    logic         chk_on;
    int           miscompares;
    int           total_checks;
    fsf_addr_type addr_tab [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h00, 8'h04, 8'h10, 8'h03};

    fsf_top fsf_top_i (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .prefetch_err(prefetch_err), .issue_fire(issue_fire),
        .issue_prefetch_err(issue_prefetch_err), .precise_data_err(precise_data_err),
        .data_err_addr(data_err_addr), .mm_data_viol(mm_data_viol),
        .mm_viol_addr(mm_viol_addr), .stack_start(stack_start), .stack_viol(stack_viol),
        .stack_done(stack_done), .sp_adjust(sp_adjust),
        .stack_ctx_suspect(stack_ctx_suspect),
        .prefetch_err_pending(prefetch_err_pending), .irq(irq)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Xorshift generator, fixed start value
    function automatic logic [31:0] rnd();
        logic [31:0] x;
        x = seed;
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        seed = x;
        return x;
    endfunction

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One cycle of random traffic; quiet keeps every request low.
    // Stacking start and end follow the model phase so no start lands mid-push.
    task automatic drive(input logic quiet);
        logic [31:0] r;
        logic        go;
        @(posedge ref_clk);
        r = rnd();
        go = !quiet;
        reg_wr <= go && r[1:0] == 2'h1;
        reg_rd <= go && r[1:0] == 2'h2;
        reg_addr <= addr_tab[r[4:2]];
        reg_wdata <= rnd();
        issue_fire <= go && r[6:5] == 2'h3;
        issue_prefetch_err <= r[7];
        prefetch_err <= go && r[9:8] == 2'h3 && r[6:5] != 2'h3;
        precise_data_err <= go && r[11:10] == 2'h3;
        data_err_addr <= rnd();
        mm_data_viol <= go && r[13:12] == 2'h3;
        mm_viol_addr <= rnd();
        stack_viol <= go && r[15:14] == 2'h3;
        stack_start <= go && r[16] && !m_push && !stack_start;
        stack_done <= go && r[17] && m_push && !stack_done && !stack_start;
    endtask

    // ------------------------------------------------------------
    // Bench model, updated on the same edges as the design
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst) begin
            m_stat <= 9'h000;
            m_mask <= 9'h000;
            m_mm <= 32'h0000_0000;
            m_bus <= 32'h0000_0000;
            m_rd <= 32'h0000_0000;
            m_push <= 1'b0;
            m_susp <= 1'b0;
            m_pend <= 1'b0;
        end else begin
            m_rd <= !reg_rd ? 32'h0000_0000 :
                    reg_addr == `FSF_OFS_STATUS ? {23'h000000, m_stat} :
                    reg_addr == `FSF_OFS_MASK ? {23'h000000, m_mask} :
                    reg_addr == `FSF_OFS_MM_ADDR ? m_mm :
                    reg_addr == `FSF_OFS_BUS_ADDR ? m_bus : 32'h0000_0000;
            // Set wins over a write-one clear in the same cycle
            m_stat <= (m_stat & ~((reg_wr && reg_addr == `FSF_OFS_STATUS) ?
                      reg_wdata[8:0] & `FSF_FLAG_BITS : 9'h000)) |
                      {issue_fire && issue_prefetch_err, mm_data_viol, 2'h0,
                       m_push && stack_viol, 4'h0};
            if (reg_wr && reg_addr == `FSF_OFS_MASK) begin
                m_mask <= reg_wdata[8:0] & `FSF_FLAG_BITS;
            end
            if (mm_data_viol) begin
                m_mm <= mm_viol_addr;
            end
            if (precise_data_err) begin
                m_bus <= data_err_addr;
            end
            m_pend <= prefetch_err ? 1'b1 : (issue_fire ? 1'b0 : m_pend);
            m_push <= (stack_start && !m_push) ? 1'b1 : ((stack_done && m_push) ? 1'b0 : m_push);
            m_susp <= (stack_start && !m_push) ? 1'b0 : ((m_push && stack_viol) ? 1'b1 : m_susp);
        end
    end

    // ------------------------------------------------------------
    // Comparison of every result, away from the active edge
    // ------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (chk_on) begin
            chk_word(reg_rdata, m_rd, "read data");
            chk_bit(irq, |(m_stat & m_mask), "irq");
            chk_bit(sp_adjust, m_push && stack_done, "sp adjust");
            chk_bit(stack_ctx_suspect, m_susp, "context suspect");
            chk_bit(prefetch_err_pending, m_pend, "prefetch pending");
        end
    end

    // ------------------------------------------------------------
    // Clock, main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        seed = 32'h0001_66B5;
        miscompares = 0;
        total_checks = 0;
        chk_on = 1'b0;
        rst = 1'b1;
        {reg_wr, reg_rd, prefetch_err, issue_fire, issue_prefetch_err} = 5'h00;
        {precise_data_err, mm_data_viol, stack_start, stack_viol, stack_done} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        data_err_addr = 32'h0000_0000;
        mm_viol_addr = 32'h0000_0000;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        chk_on = 1'b1;
        repeat (3000) drive(1'b0);
        // Reset in mid-run clears every flag and capture
        rst <= 1'b1;
        repeat (3) drive(1'b1);
        rst <= 1'b0;
        repeat (3000) drive(1'b0);
        // Handler sees the address-valid flag set, clears it, then reads it back
        drive(1'b1);
        @(posedge ref_clk);
        mm_data_viol <= 1'b1;
        @(posedge ref_clk);
        mm_data_viol <= 1'b0;
        reg_addr <= `FSF_OFS_STATUS;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_wdata <= 32'h0000_0080;
        @(negedge ref_clk);
        chk_bit(reg_rdata[`FSF_BIT_ADDR_VALID], 1'b1, "valid before clear");
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        chk_bit(reg_rdata[`FSF_BIT_ADDR_VALID], 1'b0, "valid after clear");
        repeat (3) @(posedge ref_clk);
        give_verdict();
    end

    initial begin
        #(8 * 20000);
        miscompares++;
        give_verdict();
    end

endmodule
`default_nettype wire
